// ===== logic/i2c_diagnostic_readback.sv
module i2c_diagnostic_readback
   import counter_readback_select_readback_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic                          clk_i,
   input  wire logic                          resetn_i,
   input  wire logic [counter_readback_select_readback_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [7:0]                    wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic      [7:0]                    rdata_o,
   input  wire logic                          scl_pin_i,
   input  wire logic                          sda_pin_i,
   input  wire logic                          baud_run_i,
   input  wire logic                          start_i,
   input  wire logic                          step_i,
   input  wire logic                          ten_bit_i,
   input  wire logic                          nack_i,
   input  wire logic                          stop_req_i,
   input  wire logic                          stop_count_i,
   output logic      [CNT_W-1:0]              baud_reload_value_o,
   output logic      [CNT_W-1:0]              baud_count_o,
   output logic                               baud_tick_o,
   output logic      [4:0]                    protocol_state_code_o
);

   import counter_readback_select_readback_pkg::*;

   logic [7:0]       reload_high_field_r;
   logic [7:0]       reload_low_field_r;
   logic             counter_readback_select_r;
   logic [4:0]       state_r;
   logic [4:0]       state_nxt;
   logic             scl_meta_r;
   logic             scl_sync_r;
   logic             sda_meta_r;
   logic             sda_sync_r;
   logic [7:0]       rdata_r;
   logic [7:0]       rdata_nxt;
   logic [CNT_W-1:0] count_w;
   logic [7:0]       state_view_w;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // picks one byte of either reload or live counter for readback
   function automatic logic [7:0] baud_byte(input logic          sel,
                                            input logic          hi,
                                            input logic [15:0]   rld,
                                            input logic [15:0]   cnt);
      logic [15:0] src;
      src = sel ? cnt : rld;
      return hi ? src[15:8] : src[7:0];
   endfunction

   function automatic logic [4:0] inc_code(input logic [4:0] c);
      return c + 5'h01;
   endfunction

   // ****************************************************************
   // baud reload and diagnostic control registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         reload_high_field_r <= BAUD_BYTE_RESET;
      end else if (wr_i && addr_i == BAUD_HIGH_OFFSET) begin
         reload_high_field_r <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         reload_low_field_r <= BAUD_BYTE_RESET;
      end else if (wr_i && addr_i == BAUD_LOW_OFFSET) begin
         reload_low_field_r <= wdata_i;
      end
   end

   // reserved bits are not stored at all, so they cannot read back
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         counter_readback_select_r <= COUNTER_READBACK_SELECT_SELECT_RESET;
      end else if (wr_i && addr_i == COUNTER_READBACK_SELECT_CTRL_OFFSET) begin
         counter_readback_select_r <= wdata_i[SEL_BIT];
      end
   end

   assign baud_reload_value_o = {reload_high_field_r,
                                 reload_low_field_r};

   // ****************************************************************
   // baud counter
   // ****************************************************************
   baud_counter #(
      .CNT_W (CNT_W)
   ) u_baud_counter (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .run_i    (baud_run_i),
      .reload_i (baud_reload_value_o),
      .count_o  (count_w),
      .tick_o   (baud_tick_o)
   );

   assign baud_count_o = count_w;

   // ****************************************************************
   // line input synchronisers
   // ****************************************************************
   // pins are asynchronous; only the second stage is ever read
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         scl_meta_r <= 1'b1;
         scl_sync_r <= 1'b1;
      end else begin
         scl_meta_r <= scl_pin_i;
         scl_sync_r <= scl_meta_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sda_meta_r <= 1'b1;
         sda_sync_r <= 1'b1;
      end else begin
         sda_meta_r <= sda_pin_i;
         sda_sync_r <= sda_meta_r;
      end
   end

   // ****************************************************************
   // protocol state tracker
   // ****************************************************************
   // codes are fixed by the software view, so not one-hot here;
   // step_i marks the end of each bit or phase from the transfer engine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_i) begin
               state_nxt = ST_START;
            end
         end
         ST_START: begin
            if (step_i) begin
               state_nxt = ten_bit_i ? ST_A1_BIT7
                                     : ST_ADDR_BIT7;
            end
         end
         ST_A1_BIT0: begin
            if (step_i) begin
               state_nxt = ST_A1_ACK;
            end
         end
         ST_A1_ACK: begin
            if (step_i) begin
               state_nxt = nack_i ? ST_STOP_A
                                  : ST_ADDR_BIT7;
            end
         end
         ST_ADDR_BIT1: begin
            if (step_i) begin
               state_nxt = ST_ADDR_RW;
            end
         end
         ST_ADDR_RW: begin
            if (step_i) begin
               state_nxt = ST_ADDR_ACK;
            end
         end
         ST_ADDR_ACK: begin
            if (step_i) begin
               if (nack_i || stop_req_i) begin
                  state_nxt = ST_STOP_A;
               end else if (start_i) begin
                  state_nxt = ST_START;
               end else begin
                  state_nxt = ST_DATA_BIT7;
               end
            end
         end
         ST_DATA_BIT0: begin
            if (step_i) begin
               state_nxt = ST_DATA_ACK;
            end
         end
         ST_DATA_ACK: begin
            if (step_i) begin
               if (nack_i) begin
                  state_nxt = ST_DATA_NACK;
               end else if (stop_req_i) begin
                  state_nxt = ST_STOP_A;
               end else if (start_i) begin
                  state_nxt = ST_START;
               end else begin
                  state_nxt = ST_DATA_BIT7;
               end
            end
         end
         ST_DATA_NACK: begin
            if (step_i) begin
               state_nxt = start_i ? ST_START : ST_STOP_A;
            end
         end
         ST_STOP_A: begin
            if (step_i) begin
               state_nxt = ST_STOP_B;
            end
         end
         ST_STOP_B: begin
            if (step_i) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            // runs of consecutive bit codes: data 02..08,
            // first address byte 10..16, address 19..1e
            if (step_i) begin
               state_nxt = inc_code(state_r);
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign protocol_state_code_o = state_r;

   // ****************************************************************
   // read path
   // ****************************************************************
   always_comb begin
      state_view_w                            = READ_IDLE_VALUE;
      state_view_w[CLK_SAMPLE_BIT]            = scl_sync_r;
      state_view_w[DATA_SAMPLE_BIT]           = sda_sync_r;
      state_view_w[STOP_COUNT_BIT]            = stop_count_i;
      state_view_w[STATE_MSB -: STATE_W]      = state_r;
   end

   always_comb begin
      rdata_nxt = READ_IDLE_VALUE;
      if (rd_i) begin
         case (addr_i)
            BAUD_HIGH_OFFSET: begin
               rdata_nxt = baud_byte(counter_readback_select_r, 1'b1,
                                     baud_reload_value_o,
                                     count_w);
            end
            BAUD_LOW_OFFSET: begin
               rdata_nxt = baud_byte(counter_readback_select_r, 1'b0,
                                     baud_reload_value_o,
                                     count_w);
            end
            STATE_VIEW_OFFSET: begin
               rdata_nxt = state_view_w;
            end
            COUNTER_READBACK_SELECT_CTRL_OFFSET: begin
               rdata_nxt = {7'h00, counter_readback_select_r};
            end
            default: begin
               rdata_nxt = READ_IDLE_VALUE;
            end
         endcase
      end
   end

   // data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_r <= READ_IDLE_VALUE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata_o = rdata_r;

endmodule

// ===== logic/counter_readback_select_readback_pkg.sv
package counter_readback_select_readback_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam int          ADDR_W             = 12;
   localparam logic [11:0] BAUD_HIGH_OFFSET   = 12'hf53;
   localparam logic [11:0] BAUD_LOW_OFFSET    = 12'hf54;
   localparam logic [11:0] STATE_VIEW_OFFSET  = 12'hf55;
   localparam logic [11:0] COUNTER_READBACK_SELECT_CTRL_OFFSET   = 12'hf56;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0]  BAUD_BYTE_RESET    = 8'hff;
   localparam logic        COUNTER_READBACK_SELECT_SELECT_RESET  = 1'b0;
   localparam logic [7:0]  READ_IDLE_VALUE    = 8'h00;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int          SEL_BIT            = 0;
   localparam int          CLK_SAMPLE_BIT     = 7;
   localparam int          DATA_SAMPLE_BIT    = 6;
   localparam int          STOP_COUNT_BIT     = 5;
   localparam int          STATE_MSB          = 4;
   localparam int          STATE_W            = 5;

   // ****************************************************************
   // protocol state codes
   // ****************************************************************
   localparam logic [4:0]  ST_IDLE            = 5'h00;
   localparam logic [4:0]  ST_START           = 5'h01;
   localparam logic [4:0]  ST_DATA_BIT7       = 5'h02;
   localparam logic [4:0]  ST_DATA_BIT0       = 5'h09;
   localparam logic [4:0]  ST_DATA_ACK        = 5'h0a;
   localparam logic [4:0]  ST_DATA_NACK       = 5'h0b;
   localparam logic [4:0]  ST_STOP_A          = 5'h0c;
   localparam logic [4:0]  ST_STOP_B          = 5'h0d;
   localparam logic [4:0]  ST_ADDR_ACK        = 5'h0e;
   localparam logic [4:0]  ST_ADDR_RW         = 5'h0f;
   localparam logic [4:0]  ST_A1_BIT7         = 5'h10;
   localparam logic [4:0]  ST_A1_BIT0         = 5'h17;
   localparam logic [4:0]  ST_A1_ACK          = 5'h18;
   localparam logic [4:0]  ST_ADDR_BIT7       = 5'h19;
   localparam logic [4:0]  ST_ADDR_BIT1       = 5'h1f;

endpackage

// ===== logic/baud_counter.sv
module baud_counter #(
   parameter int CNT_W = 16
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             run_i,
   input  wire logic [CNT_W-1:0] reload_i,
   output logic      [CNT_W-1:0] count_o,
   output logic                  tick_o
);

   localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   logic [CNT_W-1:0] count_r;
   logic             tick_r;

   // ****************************************************************
   // down counter, reloads after reaching one
   // ****************************************************************
   // stopped counter tracks the reload so a new rate takes effect at once
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         count_r <= {CNT_W{1'b1}};
         tick_r  <= 1'b0;
      end else if (!run_i) begin
         count_r <= reload_i;
         tick_r  <= 1'b0;
      end else if (count_r <= ONE) begin
         count_r <= reload_i;
         tick_r  <= 1'b1;
      end else begin
         count_r <= count_r - ONE;
         tick_r  <= 1'b0;
      end
   end

   assign count_o = count_r;
   assign tick_o  = tick_r;

endmodule

// ===== tb/i2c_line_model.sv
module i2c_line_model (
   input  wire logic scl_low_i,
   input  wire logic sda_low_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // open drain with pull-ups: a released line reads high, never stale
   assign scl_o = !scl_low_i;
   assign sda_o = !sda_low_i;
endmodule

// ===== tb/counter_readback_select_readback_assertions.sv
module counter_readback_select_readback_assertions
   import counter_readback_select_readback_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic                                 clk_i,
   input  wire logic                                 resetn_i,
   input  wire logic [counter_readback_select_readback_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [7:0]                           wdata_i,
   input  wire logic                                 wr_i,
   input  wire logic                                 rd_i,
   input  wire logic [7:0]                           rdata_o,
   input  wire logic                                 start_i,
   input  wire logic                                 step_i,
   input  wire logic                                 nack_i,
   input  wire logic                                 stop_count_i,
   input  wire logic [CNT_W-1:0]                     baud_reload_value_o,
   input  wire logic [CNT_W-1:0]                     baud_count_o,
   input  wire logic [4:0]                           protocol_state_code_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import counter_readback_select_readback_pkg::*;
   logic       sel_r;
   logic [4:0] st;
   assign st = protocol_state_code_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ****************************************************************
   // shadow of the select bit, so read checks know the mode
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i)
         sel_r <= COUNTER_READBACK_SELECT_SELECT_RESET;
      else if (wr_i && addr_i == COUNTER_READBACK_SELECT_CTRL_OFFSET)
         sel_r <= wdata_i[SEL_BIT];
   end
   // ****************************************************************
   // properties
   // ****************************************************************
   AST_IDLE_ZERO: assert property (!rd_i |=> rdata_o == READ_IDLE_VALUE)
      else $error("read data not zero outside a read");
   AST_LOW_WRITE: assert property (wr_i && addr_i == BAUD_LOW_OFFSET
      |=> baud_reload_value_o[7:0] == $past(wdata_i))
      else $error("low reload byte not written");
   AST_HIGH_WRITE: assert property (wr_i && addr_i == BAUD_HIGH_OFFSET
      |=> baud_reload_value_o[15:8] == $past(wdata_i))
      else $error("high reload byte not written");
   AST_LOW_NORMAL: assert property (rd_i && addr_i == BAUD_LOW_OFFSET
      && !sel_r |=> rdata_o == $past(baud_reload_value_o[7:0]))
      else $error("low byte read not reload");
   AST_LOW_COUNTER_READBACK_SELECT: assert property (rd_i && addr_i == BAUD_LOW_OFFSET
      && sel_r |=> rdata_o == $past(baud_count_o[7:0]))
      else $error("low byte read not counter");
   AST_HIGH_READ: assert property (rd_i && addr_i == BAUD_HIGH_OFFSET
      |=> rdata_o == (sel_r ? $past(baud_count_o[15:8])
                            : $past(baud_reload_value_o[15:8])))
      else $error("high byte read wrong");
   AST_VIEW_READ: assert property (rd_i && addr_i == STATE_VIEW_OFFSET
      |=> rdata_o[5:0] == {$past(stop_count_i), $past(st)})
      else $error("state view low bits wrong");
   AST_CTRL_READ: assert property (rd_i && addr_i == COUNTER_READBACK_SELECT_CTRL_OFFSET
      |=> rdata_o == {7'h00, sel_r})
      else $error("control read wrong");
   AST_START_CODE: assert property (st == ST_IDLE && start_i
      |=> st == ST_START)
      else $error("start code missing");
   AST_BIT_ORDER: assert property (step_i && st inside {[5'h02:5'h08],
      [5'h10:5'h17], [5'h19:5'h1e]} |=> st == $past(st) + 5'h01)
      else $error("bit codes out of order");
   AST_NACK_HALF: assert property (st == ST_DATA_ACK && step_i && nack_i
      |=> st == ST_DATA_NACK)
      else $error("nack half missing");
   AST_STOP_SEQ: assert property (st == ST_STOP_A && step_i
      |=> st == ST_STOP_B)
      else $error("stop second part missing");
   AST_HOLD: assert property (!step_i && st != ST_IDLE |=> $stable(st))
      else $error("state moved without a step");
endmodule

bind i2c_diagnostic_readback counter_readback_select_readback_assertions #(.CNT_W(CNT_W)) u_chk (
   .clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .start_i,
   .step_i, .nack_i, .stop_count_i, .baud_reload_value_o, .baud_count_o,
   .protocol_state_code_o);

// ===== tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import counter_readback_select_readback_pkg::*;
   logic clk_i, resetn_i, wr_i, rd_i, run_i, start_i, step_i, ten_i, nack_i;
   logic stop_req_i, stop_count_i, scl_low, sda_low, scl_w, sda_w, tick;
   logic [11:0] addr_i;
   logic [7:0]  wdata_i, rdata_o, d;
   logic [15:0] reload, count;
   logic [4:0]  code, exp_r;
   int seed = 32'h0d57;
   int miscompares = 0;
   int total_checks = 0;
   int n;
   i2c_line_model u_i2c_line_model (.scl_low_i(scl_low), .sda_low_i(sda_low),
      .scl_o(scl_w), .sda_o(sda_w));
   i2c_diagnostic_readback u_i2c_diagnostic_readback (.clk_i, .resetn_i,
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .scl_pin_i(scl_w),
      .sda_pin_i(sda_w), .baud_run_i(run_i), .start_i, .step_i,
      .ten_bit_i(ten_i), .nack_i, .stop_req_i, .stop_count_i,
      .baud_reload_value_o(reload), .baud_count_o(count),
      .baud_tick_o(tick), .protocol_state_code_o(code));
   // ****************************************************************
   // expected protocol state, following the engine strobes
   // ****************************************************************
   function automatic logic [4:0] nxt(input logic [4:0] c,
                                      input logic st, sp, tn, nk, rq);
      if (c == ST_IDLE) return st ? ST_START : c;
      if (!sp) return c;
      case (c)
         ST_START:     return tn ? ST_A1_BIT7 : ST_ADDR_BIT7;
         ST_A1_ACK:    return nk ? ST_STOP_A : ST_ADDR_BIT7;
         ST_ADDR_BIT1: return ST_ADDR_RW;
         ST_ADDR_RW:   return ST_ADDR_ACK;
         ST_ADDR_ACK:  return (nk || rq) ? ST_STOP_A :
                               st ? ST_START : ST_DATA_BIT7;
         ST_DATA_BIT0: return ST_DATA_ACK;
         ST_DATA_ACK:  return nk ? ST_DATA_NACK : rq ? ST_STOP_A :
                               st ? ST_START : ST_DATA_BIT7;
         ST_DATA_NACK: return st ? ST_START : ST_STOP_A;
         ST_STOP_A:    return ST_STOP_B;
         ST_STOP_B:    return ST_IDLE;
         default:      return c + 5'h01;
      endcase
   endfunction
   always @(posedge clk_i)
      exp_r <= !resetn_i ? ST_IDLE :
               nxt(exp_r, start_i, step_i, ten_i, nack_i, stop_req_i);
   // ****************************************************************
   // bus tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      give_verdict();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {resetn_i, wr_i, rd_i, run_i, start_i, step_i, ten_i, nack_i} = '0;
      {stop_req_i, stop_count_i, scl_low, sda_low} = '0;
      addr_i = '0;
      wdata_i = '0;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(BAUD_HIGH_OFFSET, 8'hff);
      rd(BAUD_LOW_OFFSET, 8'hff);
      rd(COUNTER_READBACK_SELECT_CTRL_OFFSET, 8'h00);
      rd(12'hf57, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         {scl_low, sda_low, stop_count_i} <= {i[1], i[0], i[0]};
         repeat (4) @(posedge clk_i);
         rd(STATE_VIEW_OFFSET, {!i[1], !i[0], i[0], ST_IDLE});
      end
      $display("test reset and view done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         wr(BAUD_LOW_OFFSET, d);
         wr(BAUD_HIGH_OFFSET, ~d);
         wr(STATE_VIEW_OFFSET, d);
         chk(reload[7:0], d);
         chk(reload[15:8], ~d);
         rd(BAUD_LOW_OFFSET, d);
         rd(BAUD_HIGH_OFFSET, ~d);
         // both lines held low by the last view step, stop count high
         rd(STATE_VIEW_OFFSET, {2'b00, 1'b1, ST_IDLE});
         wr(COUNTER_READBACK_SELECT_CTRL_OFFSET, d | 8'h01);
         rd(COUNTER_READBACK_SELECT_CTRL_OFFSET, 8'h01);
         wr(COUNTER_READBACK_SELECT_CTRL_OFFSET, d & 8'hfe);
         rd(COUNTER_READBACK_SELECT_CTRL_OFFSET, 8'h00);
      end
      $display("test registers done");
      wr(BAUD_HIGH_OFFSET, 8'h12);
      wr(BAUD_LOW_OFFSET, 8'h34);
      wr(COUNTER_READBACK_SELECT_CTRL_OFFSET, 8'h01);
      @(posedge clk_i);
      run_i <= 1'b1;
      // counter drops one per edge while running
      rd(BAUD_LOW_OFFSET, 8'h33);
      rd(BAUD_HIGH_OFFSET, 8'h12);
      @(posedge clk_i);
      run_i <= 1'b0;
      wr(BAUD_HIGH_OFFSET, 8'h00);
      wr(BAUD_LOW_OFFSET, 8'h03);
      @(posedge clk_i);
      run_i <= 1'b1;
      n = 0;
      repeat (31) begin
         @(posedge clk_i);
         #1;
         n += (tick === 1'b1);
      end
      chk(n[7:0], 8'd10);
      @(posedge clk_i);
      run_i <= 1'b0;
      wr(COUNTER_READBACK_SELECT_CTRL_OFFSET, 8'h00);
      rd(BAUD_LOW_OFFSET, 8'h03);
      $display("test counter readback done");
      repeat (800) begin
         @(posedge clk_i);
         step_i <= 1'($random(seed));
         start_i <= ($random(seed) & 3) == 0;
         nack_i <= ($random(seed) & 7) == 0;
         stop_req_i <= ($random(seed) & 3) == 0;
         ten_i <= 1'($random(seed));
         #1;
         chk({3'b000, code}, {3'b000, exp_r});
      end
      $display("test protocol states done");
      give_verdict();
   end
endmodule
